/* dcarb_defines.svh */
// Constants for the D-channel arbiter: register offsets, fields, timing
// Assumes the includer wants plain `define names; no logic here
`ifndef DCARB_DEFINES_SVH
`define DCARB_DEFINES_SVH

// ===========================================================================
// Register byte offsets
`define DCARB_OFF_MODE      12'h000
`define DCARB_OFF_CHEN      12'h004
`define DCARB_OFF_CCFG      12'h008
`define DCARB_OFF_CMD       12'h00C
`define DCARB_OFF_STAT      12'h010
`define DCARB_OFF_FIFO      12'h014

// ===========================================================================
// Fields and values
`define DCARB_MODE_ARB_BIT  0
`define DCARB_CM_LSB        0
`define DCARB_CM_ARB        2'h3
`define DCARB_CMD_RMC       8'h80
`define DCARB_CMD_RHR_BIT   6
`define DCARB_CHEN_RST      32'h0000_0000

// ===========================================================================
// Timing: 125 us multiplex frame at 20 MHz
`define DCARB_FRAME_NS      125000
`define DCARB_CLK_NS        50
`define DCARB_FRAME_CYC     (`DCARB_FRAME_NS / `DCARB_CLK_NS)
`define DCARB_BITS_PER_FRM  2

// ===========================================================================
// Receive FIFO and channel count
`define DCARB_FIFO_DEPTH    32
`define DCARB_FIFO_AW       5
`define DCARB_NCH           32

`endif

/* dcarb_pkg.sv */
// Types for the D-channel arbiter
// Widths are written as literals, not taken from dcarb_defines.svh constants
package dcarb_pkg;
   typedef enum logic [2:0] {
      ST_SUSPENDED,
      ST_FULL_SEL,
      ST_EXPECT,
      ST_RECEIVE,
      ST_LIMITED
   } dcarb_state_e;

   // Byte from a subscriber's HDLC receiver
   typedef struct packed {
      logic       valid;
      logic       open;
      logic       close;
      logic [7:0] data;
   } dcarb_rxbyte_s;

   typedef logic [31:0] dcarb_word_t;
endpackage : dcarb_pkg

/* dcarb_fifo_mem.sv */
// Receive FIFO storage: one write port, one registered read port
// Assumes the caller manages pointers and full/empty
`include "dcarb_defines.svh"
`timescale 1ns/1ps
module dcarb_fifo_mem (
   // Clock
   input  wire logic                          clk,
   // Write side
   input  wire logic                          wrEn,
   input  wire logic [`DCARB_FIFO_AW-1:0]     wrAddr,
   input  wire logic [7:0]                    wrData,
   // Read side
   input  wire logic [`DCARB_FIFO_AW-1:0]     rdAddr,
   output logic      [7:0]                    rdData
);
   logic [7:0] mem [`DCARB_FIFO_DEPTH];

   always_ff @(posedge clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
   end
endmodule : dcarb_fifo_mem

/* dcarb_arbiter.sv */
// D-channel arbiter with shared HDLC receiver FIFO and APB registers
// Assumes subscriber bytes arrive already deframed, synchronous to clk
//
// Function
// - With arbitration bit set, serve every subscriber enabled in channel-enable register.
// - Opening flag in full selection moves via expect-frame to receive-frame.
// - Room for frame plus one byte: frame end leads to limited selection.
// - Frame end signalled only when the status byte is written or on command 80.
// - No room for status byte: no frame end, stay in receive-frame.
// - Stuck selected subscriber gets no block; further frames raise overflow flag.
// - While held, all other enabled channels keep the blocked indication.
// - Clock mode written other than 3 forces suspended state.
// - Command 80 makes internal frame end, moving to limited selection.
// - Receiver reset command does not reset the arbiter state.
// - Round-robin order: worst wait twice average, zero when token arrives.
// - Limited selection rotates grant among requesters in token order.
// - Two HDLC bits per channel every 125 us multiplex frame.
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`include "dcarb_defines.svh"
`timescale 1ns/1ps
module dcarb_arbiter (
   // Clock and reset
   input  wire logic                        clk,
   input  wire logic                        srst,
   // APB slave
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [11:0]                 paddr,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   // Subscriber side: requests and bytes of the selected channel
   input  wire logic [`DCARB_NCH-1:0]       chReq,
   input  wire dcarb_pkg::dcarb_rxbyte_s    rxByte,
   output logic      [`DCARB_NCH-1:0]       chBlocked,
   output logic      [4:0]                  selChan,
   output logic                             frameTick,
   output logic      [2:0]                  arbState
);
   // =========================================================================
   // Registers
   logic                      arbMode_q;
   logic [31:0]               chEn_q;
   logic [1:0]                clkMode_q;
   logic                      ovfl_q;
   logic                      frameEnd_q;
   dcarb_pkg::dcarb_state_e   state_q, state_d;
   logic [4:0]                sel_q, sel_d;
   logic [15:0]               frmCnt_q;
   logic [`DCARB_FIFO_AW:0]   wrPtr_q, rdPtr_q;

   // =========================================================================
   // APB decode
   wire        apbAcc   = psel && penable;
   wire        apbWr    = apbAcc && pwrite;
   wire        apbRd    = apbAcc && !pwrite;
   // Full offset match; a partial decode would alias the spare space
   function automatic logic hitOf(input logic [11:0] addr, input logic [11:0] off);
      return addr == off;
   endfunction : hitOf

   wire        hitMode  = hitOf(paddr, `DCARB_OFF_MODE);
   wire        hitChen  = hitOf(paddr, `DCARB_OFF_CHEN);
   wire        hitCcfg  = hitOf(paddr, `DCARB_OFF_CCFG);
   wire        hitCmd   = hitOf(paddr, `DCARB_OFF_CMD);
   wire        hitStat  = hitOf(paddr, `DCARB_OFF_STAT);
   wire        hitFifo  = hitOf(paddr, `DCARB_OFF_FIFO);
   wire        hitAny   = hitMode | hitChen | hitCcfg | hitCmd | hitStat | hitFifo;
   wire        wrCcfg   = apbWr && hitCcfg;
   wire [1:0]  newCm    = pwdata[`DCARB_CM_LSB +: 2];
   wire        cmdRmc   = apbWr && hitCmd && pwdata[7:0] == `DCARB_CMD_RMC;
   wire        cmdRhr   = apbWr && hitCmd && pwdata[`DCARB_CMD_RHR_BIT];
   wire        popFifo  = apbRd && hitFifo;

   // =========================================================================
   // Receive FIFO status
   wire [`DCARB_FIFO_AW:0] fill  = wrPtr_q - rdPtr_q;
   wire        fifoEmpty = fill == '0;
   wire        fifoFull  = fill == (`DCARB_FIFO_AW+1)'(`DCARB_FIFO_DEPTH);
   wire        inFrame   = state_q == dcarb_pkg::ST_RECEIVE;
   wire        dataByte  = inFrame && rxByte.valid && !rxByte.close;
   // Status byte is written only on close with a free slot
   wire        staWrite  = inFrame && rxByte.valid && rxByte.close && !fifoFull;
   wire        pushByte  = (dataByte && !fifoFull) || staWrite;
   wire        frameEnd  = staWrite || cmdRmc;
   // Opening flag after a lost status byte: overflow, not rejected
   wire        ovflEvt   = inFrame && rxByte.valid && (rxByte.open || (dataByte && fifoFull));

   wire        armed     = arbMode_q && clkMode_q == `DCARB_CM_ARB;
   wire [31:0] reqEn     = chReq & chEn_q;

   // Next requester after the current grant, round robin
   function automatic logic [4:0] nextReq(input logic [31:0] req, input logic [4:0] cur);
      logic [4:0] pick;
      logic [4:0] idx;
      pick = cur;
      for (int k = 32; k >= 1; k--) begin
         idx = cur + 5'(k);
         if (req[idx]) begin
            pick = idx;
         end
      end
      return pick;
   endfunction : nextReq

   wire [4:0]  nextSel = nextReq(reqEn, sel_q);

   // =========================================================================
   // Arbiter state machine
   always_comb begin
      state_d = state_q;
      sel_d   = sel_q;
      case (state_q)
         dcarb_pkg::ST_SUSPENDED: begin
            if (armed) begin
               state_d = dcarb_pkg::ST_FULL_SEL;
            end
         end
         dcarb_pkg::ST_FULL_SEL: begin
            if (rxByte.valid && rxByte.open && reqEn[nextSel]) begin
               sel_d   = nextSel;
               state_d = dcarb_pkg::ST_EXPECT;
            end
         end
         dcarb_pkg::ST_EXPECT: begin
            state_d = dcarb_pkg::ST_RECEIVE;
         end
         dcarb_pkg::ST_RECEIVE: begin
            // Receiver reset is not a way out
            if (frameEnd) begin
               state_d = dcarb_pkg::ST_LIMITED;
            end
         end
         dcarb_pkg::ST_LIMITED: begin
            if (reqEn != '0 && rxByte.valid && rxByte.open) begin
               sel_d   = nextSel;
               state_d = dcarb_pkg::ST_EXPECT;
            end else if (reqEn == '0) begin
               state_d = dcarb_pkg::ST_FULL_SEL;
            end
         end
         default: begin
            state_d = dcarb_pkg::ST_SUSPENDED;
         end
      endcase
      // Clock mode change overrides everything
      if (wrCcfg && newCm != `DCARB_CM_ARB) begin
         state_d = dcarb_pkg::ST_SUSPENDED;
      end else if (!armed && !(wrCcfg && apbWr)) begin
         state_d = dcarb_pkg::ST_SUSPENDED;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_q <= dcarb_pkg::ST_SUSPENDED;
         sel_q   <= '0;
      end else begin
         state_q <= state_d;
         sel_q   <= sel_d;
      end
   end

   // =========================================================================
   // Control registers
   always_ff @(posedge clk) begin
      if (srst) begin
         arbMode_q <= 1'b0;
      end else if (apbWr && hitMode) begin
         arbMode_q <= pwdata[`DCARB_MODE_ARB_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         chEn_q <= `DCARB_CHEN_RST;
      end else if (apbWr && hitChen) begin
         chEn_q <= pwdata;
      end
   end

   // Clock mode resets off the arbitration code, so the arbiter waits suspended
   always_ff @(posedge clk) begin
      if (srst) begin
         clkMode_q <= 2'h0;
      end else if (wrCcfg) begin
         clkMode_q <= newCm;
      end
   end

   // Sticky flags: set wins over write-one-to-clear, so no event is lost
   wire        clrOvfl  = apbWr && hitStat && pwdata[8];
   wire        clrEnd   = apbWr && hitStat && pwdata[9];

   always_ff @(posedge clk) begin
      if (srst) begin
         ovfl_q <= 1'b0;
      end else begin
         ovfl_q <= ovflEvt || (ovfl_q && !clrOvfl);
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         frameEnd_q <= 1'b0;
      end else begin
         frameEnd_q <= frameEnd || (frameEnd_q && !clrEnd);
      end
   end

   // =========================================================================
   // FIFO pointers and storage; receiver reset only flushes the FIFO
   always_ff @(posedge clk) begin
      if (srst || cmdRhr) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
      end else begin
         if (pushByte) begin
            wrPtr_q <= wrPtr_q + 1'b1;
         end
         if (popFifo && !fifoEmpty) begin
            rdPtr_q <= rdPtr_q + 1'b1;
         end
      end
   end

   logic [7:0] fifoRd;
   wire  [7:0] pushData = staWrite ? 8'hA0 : rxByte.data;
   wire  [`DCARB_FIFO_AW-1:0] rdNext = (popFifo && !fifoEmpty) ?
         rdPtr_q[`DCARB_FIFO_AW-1:0] + 1'b1 : rdPtr_q[`DCARB_FIFO_AW-1:0];

   dcarb_fifo_mem uMem (
      .clk    (clk),
      .wrEn   (pushByte),
      .wrAddr (wrPtr_q[`DCARB_FIFO_AW-1:0]),
      .wrData (pushData),
      .rdAddr (rdNext),
      .rdData (fifoRd)
   );

   // =========================================================================
   // Multiplex frame tick, one per 125 us
   always_ff @(posedge clk) begin
      if (srst || frmCnt_q == 16'(`DCARB_FRAME_CYC - 1)) begin
         frmCnt_q <= '0;
      end else begin
         frmCnt_q <= frmCnt_q + 1'b1;
      end
   end

   // =========================================================================
   // Blocking: in receive, selected channel sees no block, other enabled channels do
   wire        busy    = state_q == dcarb_pkg::ST_EXPECT || inFrame;
   wire        asleep  = state_q == dcarb_pkg::ST_SUSPENDED;
   logic [`DCARB_NCH-1:0] blkNext;

   // Held channel is never blocked, so it may keep sending while stuck
   for (genvar g = 0; g < `DCARB_NCH; g++) begin : gBlk
      assign blkNext[g] = chEn_q[g] && (asleep || (busy && sel_q != 5'(g)));
   end

   wire [31:0] rdMux =
      hitMode ? {31'h0, arbMode_q} :
      hitChen ? chEn_q :
      hitCcfg ? {30'h0, clkMode_q} :
      hitStat ? {22'h0, frameEnd_q, ovfl_q, sel_q, state_q} :
      hitFifo ? {23'h0, fifoEmpty, 8'h0} :
      32'h0000_0000;

   // =========================================================================
   // APB answer, registered in the setup cycle so it stands in the access cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         prdata  <= '0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !hitAny;
         prdata  <= rdMux | (hitFifo ? {24'h0, fifoRd} : 32'h0);
      end
   end

   // =========================================================================
   // Subscriber-side outputs; they trail the state by one cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         chBlocked <= '0;
         selChan   <= '0;
         arbState  <= '0;
      end else begin
         chBlocked <= blkNext;
         selChan   <= sel_q;
         arbState  <= state_q;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         frameTick <= 1'b0;
      end else begin
         frameTick <= frmCnt_q == 16'(`DCARB_FRAME_CYC - 1);
      end
   end
endmodule : dcarb_arbiter

/* dcarb_arbiter_props.sv */
// Checker for the D-channel arbiter, seen from its ports only
// Assumes a bind onto dcarb_arbiter; one clock, srst synchronous high
`include "dcarb_defines.svh"
`timescale 1ns/1ps
module dcarb_arbiter_props (
   // Clock and reset
   input wire logic                     clk,
   input wire logic                     srst,
   // APB
   input wire logic                     psel,
   input wire logic                     penable,
   input wire logic                     pwrite,
   input wire logic [11:0]              paddr,
   input wire logic [31:0]              pwdata,
   input wire logic                     pready,
   // Subscriber side
   input wire dcarb_pkg::dcarb_rxbyte_s rxByte,
   input wire logic [`DCARB_NCH-1:0]    chBlocked,
   input wire logic [4:0]               selChan,
   input wire logic                     frameTick,
   input wire logic [2:0]               arbState
);
   // ====================
   // Shadow of the writes
   wire         wrTake = psel & penable & pready & pwrite;
   wire         rmcTake = wrTake && paddr == `DCARB_OFF_CMD && pwdata[7:0] == `DCARB_CMD_RMC;
   wire         cmTake = wrTake && paddr == `DCARB_OFF_CCFG;
   wire         endCause = rmcTake | (rxByte.valid & rxByte.close);
   logic [31:0] chen_q;
   logic        mode_q;
   logic [1:0]  cm_q;
   logic [11:0] tick_q;
   logic        seen_q;
   logic [2:0]  age_q;
   always_ff @(posedge clk) begin
      if (srst) begin
         {chen_q, mode_q, cm_q, tick_q, seen_q} <= '0;
         age_q <= 3'h7;
      end else begin
         if (wrTake && paddr == `DCARB_OFF_CHEN) chen_q <= pwdata;
         if (wrTake && paddr == `DCARB_OFF_MODE) mode_q <= pwdata[`DCARB_MODE_ARB_BIT];
         if (cmTake) cm_q <= pwdata[1:0];
         tick_q <= frameTick ? 12'h000 : tick_q + 12'h001;
         seen_q <= seen_q | frameTick;
         // Saturates so an old cause cannot excuse a late frame end
         age_q <= endCause ? 3'h0 : age_q + {2'h0, age_q != 3'h7};
      end
   end
   // ====================
   // Properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   a_reset_susp: assert property ($fell(srst) |-> arbState == 3'h0)
      else $error("not suspended after reset");
   a_leave_susp: assert property ($past(arbState) == 3'h0 && arbState != 3'h0 |-> mode_q && cm_q == `DCARB_CM_ARB)
      else $error("left suspended without mode");
   a_open_expect: assert property (arbState == 3'h1 && rxByte.valid && rxByte.open |-> ##[1:3] arbState == 3'h2)
      else $error("opening flag ignored");
   a_end_cause: assert property ($past(arbState) == 3'h3 && arbState == 3'h4 |-> age_q <= 3'h4)
      else $error("frame end without cause");
   a_rmc_limited: assert property (rmcTake && arbState == 3'h3 |-> ##[1:4] arbState == 3'h4)
      else $error("complete command ignored");
   a_cm_suspend: assert property (cmTake && pwdata[1:0] != `DCARB_CM_ARB |-> ##[1:4] arbState == 3'h0)
      else $error("clock mode did not suspend");
   a_rhr_keep: assert property (wrTake && paddr == `DCARB_OFF_CMD && pwdata[7:0] == 8'h40 && arbState == 3'h3
                                |=> arbState == 3'h3 [*3])
      else $error("receiver reset moved arbiter");
   a_held_block: assert property (arbState == 3'h3 && $past(arbState) == 3'h3
                                  |-> chBlocked == ($past(chen_q) & ~(32'h0000_0001 << selChan)))
      else $error("blocked set wrong while held");
   a_sel_enabled: assert property (arbState == 3'h3 |-> chen_q[selChan])
      else $error("grant to disabled channel");
   a_frame_tick: assert property (frameTick && seen_q |-> tick_q == 12'd2499)
      else $error("frame tick period wrong");
   a_tick_bound: assert property (tick_q <= 12'd2500)
      else $error("frame tick missing");
endmodule : dcarb_arbiter_props

/* dcarb_subscriber_model.sv */
// Subscriber HDLC senders, already deframed to bytes
// Assumes the testbench calls send; GAP spaces bytes
`include "dcarb_defines.svh"
`timescale 1ns/1ps
module dcarb_subscriber_model #(
   // Real pace is four frames a byte; benches shorten it
   parameter int GAP = 4 * `DCARB_FRAME_CYC
) (
   // Clock
   input wire logic                 clk,
   // To the arbiter
   output logic [`DCARB_NCH-1:0]    chReq,
   output dcarb_pkg::dcarb_rxbyte_s rxByte
);
   initial begin
      chReq = '0;
      rxByte = '0;
   end
   task automatic put(input logic o, input logic c, input logic [7:0] d);
      @(posedge clk);
      rxByte <= '{1'b1, o, c, d};
      @(posedge clk);
      // Idle data is scrambled so nothing reads a stale byte
      rxByte <= '{1'b0, 1'b0, 1'b0, ~d};
      repeat (GAP - 1) @(posedge clk);
   endtask : put
   task automatic send(input int ch, input int n);
      @(posedge clk);
      chReq[ch] <= 1'b1;
      put(1'b1, 1'b0, 8'h7E);
      for (int i = 0; i < n; i++) put(1'b0, 1'b0, 8'h10 + 8'(i));
      put(1'b0, 1'b1, 8'h7E);
      @(posedge clk);
      chReq[ch] <= 1'b0;
   endtask : send
endmodule : dcarb_subscriber_model

/* dcarb_arbiter_tb.sv */
// Testbench for dcarb_arbiter: APB tasks, subscriber model, checks
// Assumes 20 MHz clock and srst held 10 cycles; checker bound below
`include "dcarb_defines.svh"
`timescale 1ns/1ps
module dcarb_arbiter_tb;
   logic                     clk = 1'b0;
   logic                     srst = 1'b1;
   logic                     psel = 1'b0;
   logic                     penable = 1'b0;
   logic                     pwrite = 1'b0;
   logic [11:0]              paddr = 12'h000;
   logic [31:0]              pwdata = 32'h0000_0000;
   logic [31:0]              prdata;
   logic                     pready;
   logic                     pslverr;
   logic [`DCARB_NCH-1:0]    chReq;
   dcarb_pkg::dcarb_rxbyte_s rxByte;
   logic [`DCARB_NCH-1:0]    chBlocked;
   logic [4:0]               selChan;
   logic                     frameTick;
   logic [2:0]               arbState;
   logic [31:0]              rd;
   logic                     err;
   int                       num_errors = 0;
   int                       n_tests = 0;
   int                       cyc = 0;
   int                       k;

   always #25 clk = ~clk;

   dcarb_arbiter dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .chReq(chReq), .rxByte(rxByte),
      .chBlocked(chBlocked), .selChan(selChan), .frameTick(frameTick), .arbState(arbState));
   dcarb_subscriber_model #(.GAP(4)) sub (.clk(clk), .chReq(chReq), .rxByte(rxByte));

   // ====================
   // Tasks
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Request stands until an edge samples pready high; data taken there
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task automatic chkState(input logic [2:0] st);
      xfer(1'b0, `DCARB_OFF_STAT, 32'h0000_0000);
      chk("state", {29'h0, rd[2:0]}, {29'h0, st});
   endtask : chkState
   task automatic results;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : results

   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         results();
      end
   end

   // ====================
   // Tests
   initial begin
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      chkState(3'h0);
      xfer(1'b0, `DCARB_OFF_CHEN, 32'h0000_0000);
      chk("chen reset", rd, `DCARB_CHEN_RST);
      xfer(1'b0, 12'h018, 32'h0000_0000);
      chk("unmapped err", {31'h0, err}, 32'h0000_0001);
      chk("unmapped data", rd, 32'h0000_0000);
      xfer(1'b1, `DCARB_OFF_CHEN, 32'h0000_000F);
      xfer(1'b1, `DCARB_OFF_CCFG, {30'h0, `DCARB_CM_ARB});
      chkState(3'h0);
      xfer(1'b1, `DCARB_OFF_MODE, 32'h0000_0001);
      chkState(3'h1);
      $display("test enable done");
      // Frame of 32 bytes fills the FIFO, leaving no room for status
      sub.send(2, 32);
      repeat (4) @(posedge clk);
      xfer(1'b0, `DCARB_OFF_STAT, 32'h0000_0000);
      chk("locked", {22'h0, rd[9:0]}, 32'h0000_0013);
      chk("blocked", chBlocked, 32'h0000_000B);
      chk("granted", {27'h0, selChan}, 32'h0000_0002);
      sub.send(2, 1);
      repeat (4) @(posedge clk);
      xfer(1'b0, `DCARB_OFF_STAT, 32'h0000_0000);
      chk("overflow", {22'h0, rd[9:0]}, 32'h0000_0113);
      chk("own blocked", {31'h0, chBlocked[2]}, 32'h0000_0000);
      xfer(1'b1, `DCARB_OFF_CMD, 32'h0000_0040);
      chkState(3'h3);
      xfer(1'b1, `DCARB_OFF_CMD, {24'h0, `DCARB_CMD_RMC});
      // Limited holds only while someone requests, so watch the state port
      repeat (2) @(posedge clk);
      chk("limited", {29'h0, arbState}, 32'h0000_0004);
      $display("test overflow done");
      for (int m = 0; m < 3; m++) begin
         xfer(1'b1, `DCARB_OFF_CCFG, 32'(m));
         chkState(3'h0);
         xfer(1'b1, `DCARB_OFF_CCFG, {30'h0, `DCARB_CM_ARB});
         chkState(3'h1);
      end
      $display("test clock mode done");
      xfer(1'b1, `DCARB_OFF_CMD, 32'h0000_0040);
      xfer(1'b1, `DCARB_OFF_STAT, 32'h0000_0300);
      sub.send(1, 3);
      chk("end limited", {29'h0, arbState}, 32'h0000_0004);
      repeat (4) @(posedge clk);
      xfer(1'b0, `DCARB_OFF_STAT, 32'h0000_0000);
      chk("frame end", rd & 32'h0000_0307, 32'h0000_0201);
      for (int i = 0; i < 3; i++) begin
         xfer(1'b0, `DCARB_OFF_FIFO, 32'h0000_0000);
         chk("fifo data", rd, 32'h0000_0010 + 32'(i));
      end
      xfer(1'b0, `DCARB_OFF_FIFO, 32'h0000_0000);
      chk("status byte", rd, 32'h0000_00A0);
      xfer(1'b0, `DCARB_OFF_FIFO, 32'h0000_0000);
      chk("fifo empty", {31'h0, rd[8]}, 32'h0000_0001);
      $display("test frame end done");
      k = 0;
      @(negedge clk);
      while (frameTick !== 1'b1 && k < 3000) begin
         @(negedge clk);
         k++;
      end
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (frameTick !== 1'b1 && k < 3000);
      chk("frame period", 32'(k), `DCARB_FRAME_CYC);
      $display("test frame tick done");
      results();
   end
endmodule : dcarb_arbiter_tb

bind dcarb_arbiter dcarb_arbiter_props u_props (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .rxByte(rxByte),
   .chBlocked(chBlocked), .selChan(selChan), .frameTick(frameTick), .arbState(arbState));
